/* File: rtl/dtc_defs.svh */
// Register indices, field positions and counts for the dual timer block
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
// Register indices; byte address is four times the index
`define DTC_IDX_CTRL     8'h88
`define DTC_IDX_MODE     8'h89
`define DTC_IDX_LOW_A    8'h8a
`define DTC_IDX_LOW_B    8'h8b
`define DTC_IDX_HIGH_A   8'h8c
`define DTC_IDX_HIGH_B   8'h8d
`define DTC_IDX_CLKSEL   8'h8e
`define DTC_IDX_TOGGLE   8'hb5
// Control register bit positions
`define DTC_FLAG_A       5
`define DTC_FLAG_B       7
`define DTC_RUN_A        4
`define DTC_RUN_B        6
// Clock select register bit positions
`define DTC_CLKMODE_A    3
`define DTC_CLKMODE_B    4
// Toggle enable register bit positions
`define DTC_OE_A         2
`define DTC_OE_B         3
// Mode register nibble width per timer
`define DTC_MODE_NIB     4
// Mode value for 13-bit counting
`define DTC_MODE_13      2'h0
// Low-byte bits that take part in 13-bit counting
`define DTC_LOW_BITS     5
// Largest 13-bit count before wrap
`define DTC_MAX_13       13'h1fff
// Slow clock divide ratio
`define DTC_PRESCALE     12
// Reset value of every register
`define DTC_RESET_BYTE   8'h00
// Bus responses
`define DTC_RESP_OKAY    2'h0
`define DTC_RESP_SLVERR  2'h2
`endif

/* File: rtl/dtc_pkg.sv */
// Types shared by the dual timer block
package dtc_pkg;
   // One register byte
   typedef logic [7:0] dtc_byte_t;
   // Per-timer nibble of the mode register
   typedef struct packed {
      logic       gate;    // Count only while gate pin high
      logic       cntSel;  // 1 = count pin falling edges
      logic [1:0] mode;    // Operating mode
   } dtc_ctl_s;
endpackage : dtc_pkg

/* File: rtl/dtc_timer.sv */
// Two 13-bit timer/counters behind an AXI4-Lite register slave
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_timer #(
   parameter int ADDR_W   = 12,            // AXI address width
   parameter int PRESCALE = `DTC_PRESCALE  // Slow clock ratio
) (
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic              ce,          // Freezes all state
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Timer pins, index 0 = timer A, 1 = timer B
   input  wire logic [1:0]        gatePin,     // Gate inputs
   input  wire logic [1:0]        countPinIn,  // Count pin level
   output logic [1:0]             countPinOut, // Toggle drive
   output logic [1:0]             countPinOe,  // Toggle drive enable
   input  wire logic [1:0]        isrEnter,    // ISR entry pulses
   output logic [1:0]             irqReq       // Overflow flags
);

   // Register state
   logic [1:0]       runQ;        // Run bits
   logic [1:0]       flagQ;       // Overflow flags
   logic [1:0]       clkModeQ;    // 1 = direct clock
   logic [1:0]       oeQ;         // Toggle output enables
   logic [1:0]       toggleQ;     // Toggle pin levels
   logic [1:0]       pinPrevQ;    // Previous count pin sample
   dtc_pkg::dtc_byte_t modeQ;     // Mode register
   dtc_pkg::dtc_byte_t lowQ [2];  // Count low bytes
   dtc_pkg::dtc_byte_t highQ [2]; // Count high bytes
   logic [3:0]       presQ;       // Divide-by-12 counter

   // Bus state
   logic [ADDR_W-1:0] awAddrQ;    // Held write address
   logic [7:0]        wDataQ;     // Held write byte
   logic              wStrbQ;     // Held lane 0 strobe
   logic              awHeldQ;    // Address captured
   logic              wHeldQ;     // Data captured

   // Combinational helpers
   logic              doWrite;    // Register write this cycle
   logic              presTick;   // Slow clock tick
   logic [1:0]        wrLow;      // Low byte write strobe
   logic [1:0]        wrHigh;     // High byte write strobe
   logic [1:0]        cntWr;      // Either count byte written
   logic [1:0]        en;         // Timer counting allowed
   logic [1:0]        tick;       // Count event
   logic [1:0]        inc;        // Counter advances
   logic [1:0]        ovf;        // 13-bit wrap
   logic [12:0]       cnt13 [2];  // 13-bit count views
   dtc_pkg::dtc_ctl_s ctl [2];    // Mode nibble per timer

   // Address match against a register index
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] idx);
      hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
   endfunction : hit

   // Known register check
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, `DTC_IDX_CTRL) | hit(a, `DTC_IDX_MODE) |
               hit(a, `DTC_IDX_LOW_A) | hit(a, `DTC_IDX_LOW_B) |
               hit(a, `DTC_IDX_HIGH_A) | hit(a, `DTC_IDX_HIGH_B) |
               hit(a, `DTC_IDX_CLKSEL) | hit(a, `DTC_IDX_TOGGLE);
   endfunction : mapped

   // Write fires once both halves are held and no response waits
   assign doWrite  = awHeldQ & wHeldQ & ~bvalid;
   assign presTick = (presQ == 4'(PRESCALE - 1));

   // Per-timer decode and count events
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         ctl[i]    = dtc_pkg::dtc_ctl_s'(modeQ[`DTC_MODE_NIB*i +:
                                                `DTC_MODE_NIB]);
         // Count bytes reached separately
         wrLow[i]  = doWrite & wStrbQ & hit(awAddrQ, i[0] ?
                     `DTC_IDX_LOW_B : `DTC_IDX_LOW_A);
         wrHigh[i] = doWrite & wStrbQ & hit(awAddrQ, i[0] ?
                     `DTC_IDX_HIGH_B : `DTC_IDX_HIGH_A);
         cntWr[i]  = wrLow[i] | wrHigh[i];
         cnt13[i]  = {highQ[i], lowQ[i][`DTC_LOW_BITS-1:0]};
         // Run bit and gate; other modes hold the count
         en[i]     = runQ[i] & (~ctl[i].gate | gatePin[i]) &
                     (ctl[i].mode == `DTC_MODE_13);
         // Pin falling edge or internal clock
         tick[i]   = ctl[i].cntSel ?
                     (pinPrevQ[i] & ~countPinIn[i]) :
                     (clkModeQ[i] | presTick);
         // A software count write wins over the increment
         inc[i]    = ce & en[i] & tick[i] & ~cntWr[i];
         ovf[i]    = inc[i] & (cnt13[i] == `DTC_MAX_13);
      end
   end

   // Shared prescaler, free running so both timers see one phase
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         presQ <= 4'h0;
      end else if (ce) begin
         presQ <= presTick ? 4'h0 : presQ + 4'h1;
      end
   end

   // Count pin sampled every clock for edge detection
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pinPrevQ <= 2'h0;
      end else if (ce) begin
         pinPrevQ <= countPinIn;
      end
   end

   // Count bytes; upper three low bits never move when counting
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 2; i++) begin
            lowQ[i]  <= `DTC_RESET_BYTE;
            highQ[i] <= `DTC_RESET_BYTE;
         end
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (wrLow[i]) begin
               lowQ[i] <= wDataQ;
            end
            if (wrHigh[i]) begin
               highQ[i] <= wDataQ;
            end
            if (inc[i]) begin
               // Wraps to zero and keeps going
               {highQ[i], lowQ[i][`DTC_LOW_BITS-1:0]} <=
                  cnt13[i] + 13'h1;
            end
         end
      end
   end

   // Run bits, mode, clock select and toggle enables
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         runQ     <= 2'h0;
         modeQ    <= `DTC_RESET_BYTE;
         clkModeQ <= 2'h0;
         oeQ      <= 2'h0;
      end else if (ce && doWrite && wStrbQ) begin
         if (hit(awAddrQ, `DTC_IDX_CTRL)) begin
            runQ <= {wDataQ[`DTC_RUN_B], wDataQ[`DTC_RUN_A]};
         end
         if (hit(awAddrQ, `DTC_IDX_MODE)) begin
            modeQ <= wDataQ;
         end
         if (hit(awAddrQ, `DTC_IDX_CLKSEL)) begin
            clkModeQ <= {wDataQ[`DTC_CLKMODE_B],
                         wDataQ[`DTC_CLKMODE_A]};
         end
         if (hit(awAddrQ, `DTC_IDX_TOGGLE)) begin
            oeQ <= {wDataQ[`DTC_OE_B], wDataQ[`DTC_OE_A]};
         end
      end
   end

   // Overflow flags: ISR clear, then software, then hardware set
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         flagQ <= 2'h0;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (isrEnter[i]) begin
               flagQ[i] <= 1'b0;
            end
            if (doWrite && wStrbQ && hit(awAddrQ, `DTC_IDX_CTRL)) begin
               flagQ[i] <= wDataQ[i[0] ? `DTC_FLAG_B :
                                         `DTC_FLAG_A];
            end
            if (ovf[i]) begin
               flagQ[i] <= 1'b1;
            end
         end
      end
   end

   // Toggle level rests high while disabled, flips on overflow
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         toggleQ <= 2'h3;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (!oeQ[i]) begin
               toggleQ[i] <= 1'b1;
            end else if (ovf[i]) begin
               toggleQ[i] <= ~toggleQ[i];
            end
         end
      end
   end

   // Pin drive; counter mode use is left to software
   assign countPinOut = toggleQ;
   assign countPinOe  = oeQ;
   assign irqReq      = flagQ;

   // Write channel: address and data taken in either order
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         awHeldQ <= 1'b0;
         wHeldQ  <= 1'b0;
         awAddrQ <= '0;
         wDataQ  <= `DTC_RESET_BYTE;
         wStrbQ  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= `DTC_RESP_OKAY;
      end else if (ce) begin
         if (awvalid && awready) begin
            awAddrQ <= awaddr;
            awHeldQ <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            // Registers are 8 bits; only lane 0 matters
            wDataQ <= wdata[7:0];
            wStrbQ <= wstrb[0];
            wHeldQ <= 1'b1;
            wready <= 1'b0;
         end
         if (doWrite) begin
            awHeldQ <= 1'b0;
            wHeldQ  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= mapped(awAddrQ) ? `DTC_RESP_OKAY :
                                         `DTC_RESP_SLVERR;
         end
         if (bvalid && bready) begin
            // Reopen only after the response is gone
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Read channel: one cycle to data, held until taken
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= `DTC_RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= mapped(araddr) ? `DTC_RESP_OKAY :
                                        `DTC_RESP_SLVERR;
            // Unmapped and reserved bits read zero
            rdata   <= '0;
            if (hit(araddr, `DTC_IDX_CTRL)) begin
               rdata[`DTC_FLAG_B] <= flagQ[1];
               rdata[`DTC_RUN_B]  <= runQ[1];
               rdata[`DTC_FLAG_A] <= flagQ[0];
               rdata[`DTC_RUN_A]  <= runQ[0];
            end
            if (hit(araddr, `DTC_IDX_MODE)) begin
               rdata[7:0] <= modeQ;
            end
            if (hit(araddr, `DTC_IDX_LOW_A)) begin
               rdata[7:0] <= lowQ[0];
            end
            if (hit(araddr, `DTC_IDX_LOW_B)) begin
               rdata[7:0] <= lowQ[1];
            end
            if (hit(araddr, `DTC_IDX_HIGH_A)) begin
               rdata[7:0] <= highQ[0];
            end
            if (hit(araddr, `DTC_IDX_HIGH_B)) begin
               rdata[7:0] <= highQ[1];
            end
            if (hit(araddr, `DTC_IDX_CLKSEL)) begin
               rdata[`DTC_CLKMODE_B] <= clkModeQ[1];
               rdata[`DTC_CLKMODE_A] <= clkModeQ[0];
            end
            if (hit(araddr, `DTC_IDX_TOGGLE)) begin
               rdata[`DTC_OE_B] <= oeQ[1];
               rdata[`DTC_OE_A] <= oeQ[0];
            end
         end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // Checks on the timer logic
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   // Both write halves held leads to a response
   sequence wrBoth;
      ce && awHeldQ && wHeldQ && !bvalid;
   endsequence

   sequence heldCountA;
      ce && !cntWr[0];
   endsequence

   a_flag_set_a: assert property (ovf[0] |=> flagQ[0])
      else $error("timer A flag not set on wrap");
   a_flag_set_b: assert property (ovf[1] |=> flagQ[1])
      else $error("timer B flag not set on wrap");
   a_isr_clear: assert property (
      ce && isrEnter[0] && !ovf[0] &&
      !(doWrite && hit(awAddrQ, `DTC_IDX_CTRL)) |=> !flagQ[0])
      else $error("ISR entry did not clear timer A flag");
   a_stop_hold_a: assert property (
      heldCountA ##0 !runQ[0] |=> $stable(cnt13[0]))
      else $error("stopped timer A moved");
   a_stop_hold_b: assert property (
      ce && !runQ[1] && !cntWr[1] |=> $stable(cnt13[1]))
      else $error("stopped timer B moved");
   a_gate_block: assert property (
      heldCountA ##0 ctl[0].gate && !gatePin[0] |=> $stable(cnt13[0]))
      else $error("closed gate let timer A count");
   a_wrap_zero: assert property (
      ovf[0] |=> cnt13[0] == 13'h0 &&
      $stable(lowQ[0][7:`DTC_LOW_BITS]))
      else $error("timer A did not wrap to zero");
   a_slow_clock: assert property (
      heldCountA ##0 en[0] && !ctl[0].cntSel && !clkModeQ[0] &&
      !presTick |=> $stable(cnt13[0]))
      else $error("timer A counted between slow ticks");
   a_edge_count: assert property (
      heldCountA ##0 en[0] && ctl[0].cntSel && pinPrevQ[0] &&
      !countPinIn[0] && cnt13[0] != `DTC_MAX_13
      |=> cnt13[0] == $past(cnt13[0]) + 13'h1)
      else $error("timer A missed a pin falling edge");
   a_toggle_flip: assert property (
      ovf[0] && oeQ[0] |=> countPinOut[0] != $past(countPinOut[0]))
      else $error("timer A toggle pin did not flip");
   a_bus_resp: assert property (wrBoth |=> bvalid)
      else $error("write gave no response");

endmodule : dtc_timer

/* File: testbench/dtc_pin_model.sv */
// Far-side pin model: gate levels, count pin source, shared pin level
`timescale 1ns/1ps
module dtc_pin_model (
   input  wire logic       mclk,
   input  wire logic [1:0] countPinOut,
   input  wire logic [1:0] countPinOe,
   output logic [1:0]      gatePin,
   output logic [1:0]      countPinIn
);
   logic [1:0] extLvl;  // Level the outside source offers

   // Outside source lets go while the block drives the shared pin
   assign countPinIn = (countPinOe & countPinOut)
                     | (~countPinOe & extLvl);

   // Gates closed, count pins idle high
   initial begin
      gatePin = 2'b00;
      extLvl  = 2'b11;
   end

   // Gate level change, just after an edge
   task automatic set_gate(input int i, input logic v);
      @(posedge mclk);
      gatePin[i] <= v;
   endtask : set_gate

   // Low held three cycles, high at least three, so every fall is sampled high then low
   task automatic pulse(input int i, input int n);
      repeat (n) begin
         @(posedge mclk);
         extLvl[i] <= 1'b0;
         repeat (3) @(posedge mclk);
         extLvl[i] <= 1'b1;
         repeat (3) @(posedge mclk);
      end
   endtask : pulse
endmodule : dtc_pin_model

/* File: testbench/tb.sv */
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
`include "dtc_defs.svh"
module tb;
   logic        mclk, nrst, ce;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, gatePin, countPinIn;
   logic [1:0]  countPinOut, countPinOe, isrEnter, irqReq;
   logic [7:0]  rv;          // Last byte read
   int          bad_count;   // Mismatches
   int          n_compared;  // Comparisons made

   dtc_timer u_dut (.mclk(mclk), .nrst(nrst), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .gatePin(gatePin), .countPinIn(countPinIn),
      .countPinOut(countPinOut), .countPinOe(countPinOe),
      .isrEnter(isrEnter), .irqReq(irqReq));
   dtc_pin_model u_pins (.mclk(mclk), .countPinOut(countPinOut),
      .countPinOe(countPinOe), .gatePin(gatePin),
      .countPinIn(countPinIn));

   // 100 ns period
   always #50 mclk = ~mclk;

   // Verdict and end of run
   task automatic stop_test();
      if (bad_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk

   // Offsets are indices, so the byte address is four times the index
   function automatic logic [11:0] ad(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : ad

   // One write; each channel released at its own handshake edge
   task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                     input logic [1:0] er = `DTC_RESP_OKAY);
      int k;
      k = 0;
      @(posedge mclk);
      awaddr  <= ad(idx);
      wdata   <= {24'h000000, d};
      wstrb   <= 4'h1;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         k++;
      end while (bvalid !== 1'b1 && k < 50);
      bready <= 1'b0;
      chk(k < 50, 1, "write hang");
      if (k >= 50) stop_test();
      chk(bresp, er, "bresp");
   endtask : wr

   // One read; data taken at the rvalid edge
   task automatic rd(input logic [7:0] idx,
                     input logic [1:0] er = `DTC_RESP_OKAY);
      int k;
      k = 0;
      @(posedge mclk);
      araddr  <= ad(idx);
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         k++;
      end while (rvalid !== 1'b1 && k < 50);
      rready <= 1'b0;
      rv = rdata[7:0];
      chk(k < 50, 1, "read hang");
      if (k >= 50) stop_test();
      chk(rresp, er, "rresp");
      chk(rdata[31:8], 0, "rdata upper");
   endtask : rd

   // Reset values, unmapped place, idle pins
   task automatic t_reset();
      logic [7:0] regs [8];
      regs = '{`DTC_IDX_CTRL, `DTC_IDX_MODE, `DTC_IDX_LOW_A,
               `DTC_IDX_LOW_B, `DTC_IDX_HIGH_A, `DTC_IDX_HIGH_B,
               `DTC_IDX_CLKSEL, `DTC_IDX_TOGGLE};
      foreach (regs[j]) begin
         rd(regs[j]);
         chk(rv, 8'h00, "reset value");
      end
      rd(8'h00, `DTC_RESP_SLVERR);
      chk(rv, 8'h00, "unmapped data");
      wr(8'h00, 8'h5a, `DTC_RESP_SLVERR);
      chk({countPinOut, countPinOe}, 4'hc, "idle pins");
   endtask : t_reset

   // Wrap 1ffd->0 on direct clock: flag, toggle, hold, flag clears
   task automatic t_wrap(input int i);
      logic [7:0] lo, hi, run, flg, c0;
      int         k;
      lo  = i ? `DTC_IDX_LOW_B : `DTC_IDX_LOW_A;
      hi  = i ? `DTC_IDX_HIGH_B : `DTC_IDX_HIGH_A;
      run = 8'h01 << (i ? `DTC_RUN_B : `DTC_RUN_A);
      flg = 8'h01 << (i ? `DTC_FLAG_B : `DTC_FLAG_A);
      k   = 0;
      wr(`DTC_IDX_CLKSEL, 8'h08 << i);
      wr(lo, 8'hfd);
      wr(hi, 8'hff);
      wr(`DTC_IDX_TOGGLE, 8'h04 << i);
      chk({countPinOe[i], countPinIn[i]}, 2'b11, "toggle idle");
      wr(`DTC_IDX_CTRL, run);
      while (irqReq[i] !== 1'b1 && k < 40) begin
         @(posedge mclk);
         k++;
      end
      #1;
      chk(irqReq[i], 1, "no overflow");
      if (k >= 40) stop_test();
      chk({countPinOe[i], countPinIn[i]}, 2'b10, "toggle pin");
      wr(`DTC_IDX_CTRL, flg);
      rd(lo);
      c0 = rv;
      chk(rv[7:5], 3'b111, "low upper bits");
      chk(rv[4:0] != 5'h00, 1, "no count after wrap");
      rd(hi);
      chk(rv, 8'h00, "high after wrap");
      repeat (30) @(posedge mclk);
      rd(lo);
      chk(rv, c0, "stopped count moved");
      rd(`DTC_IDX_CTRL);
      chk(rv, flg, "control readback");
      @(posedge mclk);
      isrEnter[i] <= 1'b1;
      @(posedge mclk);
      isrEnter[i] <= 1'b0;
      @(posedge mclk);
      #1;
      chk(irqReq[i], 0, "isr clear");
      wr(`DTC_IDX_CTRL, flg);
      chk(irqReq[i], 1, "software set");
      wr(`DTC_IDX_CTRL, 8'h00);
      chk(irqReq[i], 0, "software clear");
      wr(`DTC_IDX_TOGGLE, 8'h00);
   endtask : t_wrap

   // Clear the count, run on the chosen clock and mode
   task automatic start(input int i, input logic [7:0] cs,
                        input logic [7:0] md);
      wr(`DTC_IDX_CLKSEL, cs);
      wr(`DTC_IDX_MODE, md);
      wr(i ? `DTC_IDX_LOW_B : `DTC_IDX_LOW_A, 8'h00);
      wr(i ? `DTC_IDX_HIGH_B : `DTC_IDX_HIGH_A, 8'h00);
      wr(`DTC_IDX_CTRL, 8'h01 << (i ? `DTC_RUN_B : `DTC_RUN_A));
   endtask : start

   // Stop and fetch the low count byte
   task automatic finish_run(input int i);
      wr(`DTC_IDX_CTRL, 8'h00);
      wr(`DTC_IDX_MODE, 8'h00);
      rd(i ? `DTC_IDX_LOW_B : `DTC_IDX_LOW_A);
   endtask : finish_run

   // Divide-by-12 clock: about 240 cycles gives 20 ticks
   task automatic t_pres(input int i);
      start(i, 8'h00, 8'h00);
      repeat (240) @(posedge mclk);
      finish_run(i);
      chk(rv >= 8'd20 && rv <= 8'd21, 1, "prescaled count");
   endtask : t_pres

   // Gate closed 40 cycles, open 20: only the open time counts
   task automatic t_gate(input int i);
      start(i, 8'h08 << i, 8'h08 << (4 * i));
      repeat (40) @(posedge mclk);
      u_pins.set_gate(i, 1'b1);
      repeat (19) @(posedge mclk);
      u_pins.set_gate(i, 1'b0);
      finish_run(i);
      chk(rv, 8'd20, "gated count");
   endtask : t_gate

   // Other modes hold the count; enable low freezes a running timer
   task automatic t_hold(input int i);
      start(i, 8'h08 << i, 8'h01 << (4 * i));
      repeat (20) @(posedge mclk);
      finish_run(i);
      chk(rv, 8'h00, "count moved outside 13-bit mode");
      start(i, 8'h08 << i, 8'h00);
      @(posedge mclk);
      ce <= 1'b0;
      repeat (30) @(posedge mclk);
      ce <= 1'b1;
      finish_run(i);
      // Five enabled edges around the frozen stretch
      chk(rv >= 8'd4 && rv <= 8'd6, 1, "count moved with enable low");
   endtask : t_hold

   // Counter mode: five pin falls give five counts
   task automatic t_cnt(input int i);
      start(i, 8'h08 << i, 8'h04 << (4 * i));
      u_pins.pulse(i, 5);
      finish_run(i);
      chk(rv, 8'd5, "edge count");
   endtask : t_cnt

   // Reset, then both timers through every scenario
   initial begin
      mclk       = 1'b0;
      nrst       = 1'b0;
      ce         = 1'b1;
      awaddr     = '0;
      araddr     = '0;
      wdata      = '0;
      wstrb      = '0;
      awvalid    = 1'b0;
      wvalid     = 1'b0;
      bready     = 1'b0;
      arvalid    = 1'b0;
      rready     = 1'b0;
      isrEnter   = 2'b00;
      bad_count  = 0;
      n_compared = 0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      for (int i = 0; i < 2; i++) begin
         t_wrap(i);
         t_pres(i);
         t_gate(i);
         t_cnt(i);
         t_hold(i);
      end
      stop_test();
   end
endmodule : tb
